/* logic/dbrel_pkg.sv */
// Purpose: shared constants for the relative-decibel offset unit
// Assumes: four-digit bcd magnitude, sign bit kept apart
// Notes:   sequence step numbers are octal program addresses
package dbrel_pkg;
    localparam int unsigned DIGITS          = 4;                 // bcd digits of magnitude
    localparam int unsigned MAG_W           = 4 * DIGITS;        // magnitude width in bits
    localparam logic [15:0] MAG_ZERO        = 16'h0000;          // reset and cleared magnitude
    localparam logic        SIGN_POS        = 1'b0;              // sign bit meaning positive
    localparam logic [7:0]  STEP_SIGN_TEST  = 8'h79;             // octal 171, count direction test
    localparam logic [7:0]  STEP_OVR_TEST_A = 8'h27;             // octal 047, over-range test a
    localparam logic [7:0]  STEP_OVR_TEST_B = 8'h28;             // octal 050, over-range test b
    localparam logic [7:0]  STEP_IDLE       = 8'h00;             // no step reported
    localparam logic [1:0]  MODE_REL        = 2'h1;              // mode code for relative operation
    localparam logic [1:0]  MODE_RESET      = 2'h0;              // mode register after reset

    typedef enum logic [2:0] {
        DBREL_IDLE,
        DBREL_CAPTURE,
        DBREL_LOAD,
        DBREL_TEST,
        DBREL_STEP,
        DBREL_DONE
    } dbrel_state_t;
endpackage

/* logic/dbrel_bcd_step.sv */
// Purpose: one signed bcd step of the main counter
// Assumes: sign-magnitude value, magnitude in packed bcd
// Notes:   purely combinational; passing zero flips the sign
`timescale 1ns/1ps
module dbrel_bcd_step (
    input  wire logic        sign,      // current sign, 1 = negative
    input  wire logic [15:0] mag,       // current magnitude
    input  wire logic        down,      // 1 = step toward zero then past it
    output logic             next_sign, // sign after the step
    output logic [15:0]      next_mag   // magnitude after the step
);
    // bcd increment of a packed four-digit value
    function automatic logic [15:0] bcd_inc(input logic [15:0] v);
        logic [15:0] r;
        logic        c;
        r = v;
        c = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (c) begin
                if (r[4*i +: 4] == 4'h9) begin
                    r[4*i +: 4] = 4'h0;
                end else begin
                    r[4*i +: 4] = r[4*i +: 4] + 4'h1;
                    c = 1'b0;
                end
            end
        end
        return r;
    endfunction

    // bcd decrement, only used on non-zero values
    function automatic logic [15:0] bcd_dec(input logic [15:0] v);
        logic [15:0] r;
        logic        b;
        r = v;
        b = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (b) begin
                if (r[4*i +: 4] == 4'h0) begin
                    r[4*i +: 4] = 4'h9;
                end else begin
                    r[4*i +: 4] = r[4*i +: 4] - 4'h1;
                    b = 1'b0;
                end
            end
        end
        return r;
    endfunction

    // at zero a down step inverts the sign and grows the magnitude again
    always_comb begin
        next_sign = sign;
        next_mag  = mag;
        if (!down) begin
            next_mag = bcd_inc(mag);
        end else if (mag == dbrel_pkg::MAG_ZERO) begin
            next_sign = ~sign;
            next_mag  = bcd_inc(mag);
        end else begin
            next_mag = bcd_dec(mag);
        end
    end
endmodule

/* logic/dbrel_offset_unit.sv */
// Purpose: relative-decibel offset datapath of a power meter
// Assumes: sequencer pulses meas_done once per reading with the main count valid
// Notes:   main count is sign-magnitude bcd; one step per clock
`timescale 1ns/1ps
module dbrel_offset_unit (
    input  wire logic        mclk,               // 20 MHz meter clock
    input  wire logic        rst,                // synchronous, active high
    input  wire logic        meas_done,          // one-cycle pulse, main count ready
    input  wire logic        meas_sign,          // measured sign, 1 = negative
    input  wire logic [15:0] meas_mag,           // measured bcd magnitude
    input  wire logic        reference_capture_key, // key pin, raw
    input  wire logic [1:0]  mode_select,        // mode select inputs
    input  wire logic        over_range,         // over-range present
    input  wire logic        ovr_seq_step,       // pulse, over-range continuation running
    output logic             relative_decibel_mode, // mode register says relative
    output logic [1:0]       mode_reg,           // mode register contents
    output logic             ref_sign,           // stored reference sign
    output logic [15:0]      ref_mag,            // stored reference magnitude
    output logic             out_sign,           // adjusted main sign
    output logic [15:0]      out_mag,            // adjusted main magnitude
    output logic             out_valid,          // pulse, display stage takes over
    output logic             busy,               // subtraction in progress
    output logic [7:0]       seq_step,           // step address under test
    output logic             sequence_test_flag_one, // flag tested at 171 and 050
    output logic             sequence_test_flag_two  // flag tested at 047
);
    logic                  key_meta;            // first sync stage
    logic                  key_sync;            // second sync stage
    dbrel_pkg::dbrel_state_t state;             // sequence state
    logic                  main_sign;           // main counter sign
    logic [15:0]           main_mag;            // main counter magnitude
    logic [15:0]           rel_cnt;             // relative down-counter
    logic                  count_down;          // direction picked at step 171
    logic                  next_main_sign;      // stepper result sign
    logic [15:0]           next_main_mag;       // stepper result magnitude

    // key crosses in from a pin
    always_ff @(posedge mclk) begin
        if (rst) begin
            key_meta <= 1'b0;
            key_sync <= 1'b0;
        end else begin
            key_meta <= reference_capture_key;
            key_sync <= key_meta;
        end
    end

    // mode register loads from the select inputs while the key is down
    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_reg              <= dbrel_pkg::MODE_RESET;
            relative_decibel_mode <= 1'b0;
        end else if (key_sync) begin
            mode_reg              <= mode_select;
            relative_decibel_mode <= (mode_select == dbrel_pkg::MODE_REL);
        end
    end

    // main sequence of the offset subtraction
    always_ff @(posedge mclk) begin
        if (rst) begin
            state    <= dbrel_pkg::DBREL_IDLE;
        end else begin
            case (state)
                dbrel_pkg::DBREL_IDLE: begin
                    // only relative mode runs the subtraction
                    if (meas_done && relative_decibel_mode) begin
                        state    <= key_sync ? dbrel_pkg::DBREL_CAPTURE
                                             : dbrel_pkg::DBREL_LOAD;
                    end
                end
                dbrel_pkg::DBREL_CAPTURE: state <= dbrel_pkg::DBREL_LOAD;
                dbrel_pkg::DBREL_LOAD:    state <= dbrel_pkg::DBREL_TEST;
                dbrel_pkg::DBREL_TEST:    state <= dbrel_pkg::DBREL_STEP;
                dbrel_pkg::DBREL_STEP: begin
                    if (rel_cnt == dbrel_pkg::MAG_ZERO) begin
                        state <= dbrel_pkg::DBREL_DONE;
                    end
                end
                dbrel_pkg::DBREL_DONE:    state <= dbrel_pkg::DBREL_IDLE;
                default:                  state <= dbrel_pkg::DBREL_IDLE;
            endcase
        end
    end

    // reference register: capture, clear on key during over-range in relative mode, else hold
    always_ff @(posedge mclk) begin
        if (rst) begin
            ref_sign <= dbrel_pkg::SIGN_POS;
            ref_mag  <= dbrel_pkg::MAG_ZERO;
        end else if (key_sync && relative_decibel_mode && over_range) begin
            ref_sign <= dbrel_pkg::SIGN_POS;
            ref_mag  <= dbrel_pkg::MAG_ZERO;
        end else if (state == dbrel_pkg::DBREL_CAPTURE) begin
            ref_sign <= main_sign;
            ref_mag  <= main_mag;
        end
    end

    // sign flags, direction chosen at step 171
    always_ff @(posedge mclk) begin
        if (rst) begin
            count_down <= 1'b1;
        end else if (state == dbrel_pkg::DBREL_TEST) begin
            // same signs move toward zero; differing signs grow the magnitude
            count_down <= (main_sign == ref_sign);
        end else if (state == dbrel_pkg::DBREL_STEP && rel_cnt != dbrel_pkg::MAG_ZERO
                     && main_mag == dbrel_pkg::MAG_ZERO) begin
            // the step through zero flips the sign, so the magnitude grows from here on
            count_down <= 1'b0;
        end
    end

    // shared stepper for the main counter
    dbrel_bcd_step u_step (
        .sign      (main_sign),
        .mag       (main_mag),
        .down      (count_down),
        .next_sign (next_main_sign),
        .next_mag  (next_main_mag)
    );

    // main and relative counters advance on the same edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            main_sign <= dbrel_pkg::SIGN_POS;
            main_mag  <= dbrel_pkg::MAG_ZERO;
            rel_cnt   <= dbrel_pkg::MAG_ZERO;
        end else begin
            if (state == dbrel_pkg::DBREL_IDLE && meas_done) begin
                main_sign <= meas_sign;
                main_mag  <= meas_mag;
            end
            if (state == dbrel_pkg::DBREL_LOAD) begin
                rel_cnt <= ref_mag;
            end
            if (state == dbrel_pkg::DBREL_STEP && rel_cnt != dbrel_pkg::MAG_ZERO) begin
                main_sign <= next_main_sign;
                main_mag  <= next_main_mag;
                rel_cnt   <= u_dec(rel_cnt);
            end
        end
    end

    // bcd decrement of the relative counter
    function automatic logic [15:0] u_dec(input logic [15:0] v);
        logic [15:0] r;
        logic        b;
        r = v;
        b = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (b) begin
                if (r[4*i +: 4] == 4'h0) begin
                    r[4*i +: 4] = 4'h9;
                end else begin
                    r[4*i +: 4] = r[4*i +: 4] - 4'h1;
                    b = 1'b0;
                end
            end
        end
        return r;
    endfunction

    // hand-off to display stage
    always_ff @(posedge mclk) begin
        if (rst) begin
            out_sign  <= dbrel_pkg::SIGN_POS;
            out_mag   <= dbrel_pkg::MAG_ZERO;
            out_valid <= 1'b0;
        end else begin
            out_valid <= (state == dbrel_pkg::DBREL_DONE);
            if (state == dbrel_pkg::DBREL_DONE) begin
                out_sign <= main_sign;
                out_mag  <= main_mag;
            end
        end
    end

    // busy and step address for the sequencer
    always_ff @(posedge mclk) begin
        if (rst) begin
            busy     <= 1'b0;
            seq_step <= dbrel_pkg::STEP_IDLE;
        end else begin
            busy <= (state != dbrel_pkg::DBREL_IDLE) && (state != dbrel_pkg::DBREL_DONE);
            if (state == dbrel_pkg::DBREL_TEST) begin
                seq_step <= dbrel_pkg::STEP_SIGN_TEST;
            end else if (ovr_seq_step && relative_decibel_mode) begin
                seq_step <= dbrel_pkg::STEP_OVR_TEST_A;
            end else if (seq_step == dbrel_pkg::STEP_OVR_TEST_A) begin
                // second test of the continuation follows on the next cycle
                seq_step <= dbrel_pkg::STEP_OVR_TEST_B;
            end else begin
                seq_step <= dbrel_pkg::STEP_IDLE;
            end
        end
    end

    // flags the over-range continuation tests; reference is never touched here
    always_ff @(posedge mclk) begin
        if (rst) begin
            sequence_test_flag_one <= 1'b0;
            sequence_test_flag_two <= 1'b0;
        end else begin
            // flag one: reference nonzero (050) or sign test (171)
            sequence_test_flag_one <= (state == dbrel_pkg::DBREL_TEST) ? (main_sign == ref_sign)
                                    : (ref_mag != dbrel_pkg::MAG_ZERO);
            // flag two low at 047 means relative mode continuation
            sequence_test_flag_two <= ~relative_decibel_mode;
        end
    end
endmodule

/* tb/dbrel_offset_props.sv */
// Purpose: port checks of the relative offset unit
// Assumes: one clock, sync active-high reset
// Notes:   the key passes two sync flops before it acts
`timescale 1ns/1ps
module dbrel_offset_props (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        reference_capture_key,
    input wire logic        over_range,
    input wire logic        relative_decibel_mode,
    input wire logic [1:0]  mode_reg,
    input wire logic        ref_sign,
    input wire logic [15:0] ref_mag,
    input wire logic        out_sign,
    input wire logic [15:0] out_mag,
    input wire logic        out_valid,
    input wire logic        busy,
    input wire logic [7:0]  seq_step
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // key and over-range held long enough to pass the sync
    sequence s_key_ovr;
        (reference_capture_key && over_range && relative_decibel_mode) [*4];
    endsequence
    // direction test follows soon after a run opens
    sequence s_dir_test;
        ##[1:5] seq_step == dbrel_pkg::STEP_SIGN_TEST;
    endsequence
    pulse_once_a: assert property (out_valid |=> !out_valid)
        else $error("hand-over pulse too long");
    ref_hold_a: assert property (!reference_capture_key [*5] |=> $stable(ref_mag) && $stable(ref_sign))
        else $error("reference moved without key");
    ovr_clear_a: assert property (s_key_ovr |-> ref_mag == dbrel_pkg::MAG_ZERO)
        else $error("reference not cleared");
    mode_load_a: assert property (
        $changed(mode_reg) |-> $past(reference_capture_key, 2) || $past(reference_capture_key, 3))
        else $error("mode changed without key");
    mode_flag_a: assert property (
        $stable(mode_reg) [*2] |-> relative_decibel_mode == (mode_reg == dbrel_pkg::MODE_REL))
        else $error("mode flag disagrees");
    sign_test_a: assert property ($rose(busy) |-> s_dir_test)
        else $error("direction test missing");
    out_hold_a: assert property ($changed(out_mag) || $changed(out_sign) |-> out_valid || $past(out_valid))
        else $error("result moved outside hand-over");
    run_end_a: assert property ($fell(busy) |-> $past(out_valid) or ##[0:2] out_valid)
        else $error("run ended without hand-over");
endmodule

bind dbrel_offset_unit dbrel_offset_props u_dbrel_offset_props (.mclk, .rst, .reference_capture_key,
    .over_range, .relative_decibel_mode, .mode_reg, .ref_sign, .ref_mag, .out_sign, .out_mag,
    .out_valid, .busy, .seq_step);

/* tb/dbrel_seq_model.sv */
// Purpose: sequencer stand-in that feeds readings
// Assumes: next reading only after the hand-over
// Notes:   lines are scrambled between readings
`timescale 1ns/1ps
module dbrel_seq_model (
    input  wire logic        mclk,      // meter clock
    input  wire logic        go,        // bench asks for a reading
    input  wire logic        rq_sign,   // sign to present
    input  wire logic [15:0] rq_mag,    // magnitude to present
    input  wire logic        out_valid, // hand-over pulse
    output logic             meas_done = 1'h0,
    output logic             meas_sign = 1'h0,
    output logic [15:0]      meas_mag = 16'h0000,
    output int               lat = 0    // cycles from take to the hand-over pulse
);
    int   cnt = 0; // edges since the reading was taken
    logic g;       // request seen at this edge
    // count from the taking edge, then drive just after the edge
    always @(posedge mclk) begin
        cnt = meas_done ? 0 : cnt + 1;
        if (out_valid === 1'h1) begin
            lat = cnt; // pulse seen at the edge closing its cycle
        end
        g = go;
        #1;
        meas_done = g;
        meas_sign = g ? rq_sign : ~meas_sign; // a stale sample cannot pass by luck
        meas_mag  = g ? rq_mag : ~meas_mag;
    end
endmodule

/* tb/tb_db_relative_offset_unit.sv */
// Purpose: bench for the relative offset unit
// Assumes: model feeds readings; bench drives key, mode and range pins
// Notes:   small bcd values keep step counts short
`timescale 1ns/1ps
module tb_db_relative_offset_unit;
    logic        mclk = 1'h0, rst = 1'h1, go = 1'h0, rq_sign = 1'h0, exp_s = 1'h0;
    logic        reference_capture_key = 1'h0, over_range = 1'h0, ovr_seq_step = 1'h0;
    logic [1:0]  mode_select = dbrel_pkg::MODE_RESET, mode_reg;
    logic [15:0] rq_mag = 16'h0000, exp_m = 16'h0000, meas_mag, ref_mag, out_mag;
    logic        meas_done, meas_sign, relative_decibel_mode, ref_sign, out_sign, out_valid, busy;
    logic        sequence_test_flag_one, sequence_test_flag_two;
    logic [7:0]  seq_step;
    int          lat, n_errors = 0, n_compared = 0;
    always #25 mclk = ~mclk; // 20 MHz
    dbrel_offset_unit u_dbrel_offset_unit (.mclk, .rst, .meas_done, .meas_sign, .meas_mag,
        .reference_capture_key, .mode_select, .over_range, .ovr_seq_step, .relative_decibel_mode,
        .mode_reg, .ref_sign, .ref_mag, .out_sign, .out_mag, .out_valid, .busy, .seq_step,
        .sequence_test_flag_one, .sequence_test_flag_two);
    dbrel_seq_model u_dbrel_seq_model (.mclk, .go, .rq_sign, .rq_mag, .out_valid, .meas_done,
        .meas_sign, .meas_mag, .lat);
    function automatic int bcd2int(input logic [15:0] b);
        return b[15:12] * 1000 + b[11:8] * 100 + b[7:4] * 10 + b[3:0];
    endfunction
    function automatic logic [15:0] int2bcd(input int v);
        return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
    endfunction
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    // wait edges, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // one reading with the key held or not; live says a hand-over is due
    task automatic reading(input logic s, input logic [15:0] m, input logic k, input logic live);
        logic hit;
        int   d;
        hit = 1'h0;
        reference_capture_key = k;
        tick(4);
        go = 1'h1;
        rq_sign = s;
        rq_mag = m;
        tick(1);
        go = 1'h0;
        for (int i = 0; i < 3000 && !hit; i++) begin
            tick(1);
            hit = (out_valid === 1'h1);
            if (!live && i > 150) break;
        end
        tick(1);
        reference_capture_key = 1'h0;
        chk("hand_over", 16'(live), 16'(hit));
        if (live && !hit) give_verdict();
        if (!live) return;
        if (k) begin
            exp_s = s;
            exp_m = m;
        end
        d = (s ? -bcd2int(m) : bcd2int(m)) - (exp_s ? -bcd2int(exp_m) : bcd2int(exp_m));
        chk("out_sign", 16'(d < 0 || (d == 0 && s)), 16'(out_sign));
        chk("out_mag", int2bcd(d < 0 ? -d : d), out_mag);
        chk("latency", 16'(bcd2int(exp_m) + 5 + k), 16'(lat));
        chk("ref_mag", exp_m, ref_mag);
        chk("ref_sign", 16'(exp_s), 16'(ref_sign));
    endtask
    // ignored outside relative mode, then the key loads the mode inputs
    task automatic t_mode();
        reading(1'h0, 16'h0010, 1'h0, 1'h0);
        mode_select = dbrel_pkg::MODE_REL;
        reference_capture_key = 1'h1;
        tick(4);
        reference_capture_key = 1'h0;
        tick(3);
        chk("mode_reg", 16'(dbrel_pkg::MODE_REL), 16'(mode_reg));
        chk("rel_mode", 16'h0001, 16'(relative_decibel_mode));
    endtask
    // positive reference, then down, through zero, and up on opposite signs
    task automatic t_follow();
        reading(1'h0, 16'h0050, 1'h1, 1'h1);
        reading(1'h0, 16'h0080, 1'h0, 1'h1);
        reading(1'h0, 16'h0020, 1'h0, 1'h1);
        reading(1'h1, 16'h0010, 1'h0, 1'h1);
    endtask
    // negative reference; up across digit carries, then down
    task automatic t_neg_ref();
        reading(1'h1, 16'h0025, 1'h1, 1'h1);
        reading(1'h0, 16'h0995, 1'h0, 1'h1);
        reading(1'h1, 16'h0030, 1'h0, 1'h1);
    endtask
    // over-range keeps the reference; key during over-range clears it
    task automatic t_over();
        over_range = 1'h1;
        ovr_seq_step = 1'h1;
        tick(1);
        ovr_seq_step = 1'h0;
        chk("seq_step", 16'(dbrel_pkg::STEP_OVR_TEST_A), 16'(seq_step));
        chk("flag_two", 16'h0000, 16'(sequence_test_flag_two));
        tick(1);
        chk("seq_step", 16'(dbrel_pkg::STEP_OVR_TEST_B), 16'(seq_step));
        tick(3);
        chk("ref_mag", exp_m, ref_mag);
        chk("flag_one", 16'h0001, 16'(sequence_test_flag_one));
        reference_capture_key = 1'h1;
        tick(5);
        reference_capture_key = 1'h0;
        over_range = 1'h0;
        exp_s = dbrel_pkg::SIGN_POS;
        exp_m = dbrel_pkg::MAG_ZERO;
        reading(1'h0, 16'h0042, 1'h0, 1'h1);
    endtask
    task automatic give_verdict();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // reset for eight cycles, then each scenario in turn
    initial begin
        tick(8);
        rst = 1'h0;
        t_mode();
        t_follow();
        t_neg_ref();
        t_over();
        give_verdict();
    end
endmodule
